//--- rtl/sadc_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic [AW-1:0]    nxt_wr_ptr;
	logic [AW-1:0]    nxt_rd_ptr;
	logic [AW:0]      nxt_count;
	logic             push;
	logic             pop;

	assign in_ready  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_ff[rd_ptr_ff];

	always_comb begin
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count  = count_ff;
		if (push) begin
			nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
		end
		if (push && !pop) begin
			nxt_count = count_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff  <= nxt_count;
		end
	end

	// Storage needs no reset; count guards reads
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end
endmodule
`default_nettype wire

//--- rtl/sadc_pkg.sv
package sadc_pkg;
	localparam int          CLK_PERIOD_NS    = 8;
	localparam int          RESULT_W         = 12;
	localparam int          BYTE_W           = 8;
	localparam int          SER_BITS         = 12;
	localparam int          FIFO_DEPTH       = 8;
	localparam int          CONV_TIME_NS     = 20000;
	localparam int          CONV_CYCLES      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          SCLK_HALF_NS     = 64;
	localparam int          SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] RESULT_RST       = 12'h000;
	localparam logic [11:0] CONV_CNT_LAST    = 12'(CONV_CYCLES - 1);
	localparam logic [3:0]  DIV_LAST         = 4'(SCLK_HALF_CYCLES - 1);
	localparam logic [3:0]  SER_LAST_BIT     = 4'(SER_BITS - 1);
	localparam int          HI_NIB_LSB       = 4;
	localparam int          LO_NIB_W         = 4;
	localparam int          SYNC_W           = 7;
	localparam int          SY_CS            = 0;
	localparam int          SY_RC            = 1;
	localparam int          SY_BYTE          = 2;
	localparam int          SY_FMT           = 3;
	localparam int          SY_CSRC          = 4;
	localparam int          SY_SCLK          = 5;
	localparam int          SY_CHAIN         = 6;

	typedef enum logic [1:0] {
		SADC_IDLE,
		SADC_CONV,
		SADC_SEND
	} sadc_state_t;
endpackage

//--- rtl/sadc_port.sv
// Summary of operation
// - Parallel result coding follows output format select.
// - Bit clock pin driven in internal mode only.
// - Byte select low: bits 11..4 on pins.
// - Byte select high: bits 3..0, low nibble zero.
// - Pins float when chip select high or strobe low.
// - Strobe fall with chip select low starts a conversion while idle.
// - Strobe rise with chip select enables drivers.
// - Chip select ORed with strobe also starts.
// - Internal mode: start sends previous result serially.
// - Busy low from start until outputs updated.
// - Analog sleep powers down analog, logic runs.
// - Reference disable turns internal reference off.
// - Serial bits shift with the bit clock.
// - External clock mode shifts in chain input.
// - Internal mode: twelve pulses, MSB first, twos complement.
// - Convert commands ignored while busy low.
`timescale 1ns/10ps
`default_nettype none
module sadc_port
	import sadc_pkg::*;
(
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                resetn,
	// Host control pins
	input  wire logic                chip_select_n,
	input  wire logic                read_convert,
	input  wire logic                byte_select,
	input  wire logic                output_format_select,
	input  wire logic                clock_source_select,
	input  wire logic                analog_sleep,
	input  wire logic                internal_ref_disable,
	output logic                     busy_n,
	// Parallel result pins
	output logic      [BYTE_W-1:0]   parallel_result_pins_o,
	output logic      [BYTE_W-1:0]   parallel_result_pins_oe_n,
	// Serial link
	input  wire logic                serial_bit_clock_i,
	output logic                     serial_bit_clock_o,
	output logic                     serial_bit_clock_oe_n,
	output logic                     serial_result_out,
	input  wire logic                serial_chain_in,
	// Converter core
	input  wire logic                sample_valid,
	input  wire logic [RESULT_W-1:0] sample_data,
	output logic                     sample_ready,
	output logic                     conv_start,
	output logic                     analog_power_down,
	output logic                     internal_ref_off
);
	logic                rst_meta_ff;
	logic                rst_n;
	logic [SYNC_W-1:0]   pin_async;
	logic [SYNC_W-1:0]   pin_sync;
	logic                cmd_n;
	logic                cmd_n_ff;
	logic                sclk_prev_ff;
	logic                ext_fall;
	logic                start;
	logic                fifo_valid;
	logic [RESULT_W-1:0] fifo_data;
	logic                fifo_pop;
	logic                bus_on;
	logic [RESULT_W-1:0] coded;
	logic [RESULT_W-1:0] prev_btc;

	sadc_state_t         state_ff;
	sadc_state_t         nxt_state;
	logic [11:0]         conv_cnt_ff;
	logic [11:0]         nxt_conv_cnt;
	logic [RESULT_W-1:0] result_ff;
	logic [RESULT_W-1:0] nxt_result;
	logic [RESULT_W-1:0] shift_ff;
	logic [RESULT_W-1:0] nxt_shift;
	logic                ser_act_ff;
	logic                nxt_ser_act;
	logic [3:0]          div_ff;
	logic [3:0]          nxt_div;
	logic [3:0]          bit_cnt_ff;
	logic [3:0]          nxt_bit_cnt;
	logic                sclk_ff;
	logic                nxt_sclk;
	logic [BYTE_W-1:0]   pdata_ff;
	logic [BYTE_W-1:0]   nxt_pdata;
	logic                pen_ff;
	logic                nxt_pen;
	logic                sleep_ff;
	logic                refoff_ff;
	logic                sleep_meta_ff;
	logic                refoff_meta_ff;

	// Reset released through two flops
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_ff <= 1'b0;
			rst_n       <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n       <= rst_meta_ff;
		end
	end

	always_comb begin
		pin_async           = '0;
		pin_async[SY_CS]    = chip_select_n;
		pin_async[SY_RC]    = read_convert;
		pin_async[SY_BYTE]  = byte_select;
		pin_async[SY_FMT]   = output_format_select;
		pin_async[SY_CSRC]  = clock_source_select;
		pin_async[SY_SCLK]  = serial_bit_clock_i;
		pin_async[SY_CHAIN] = serial_chain_in;
	end

	sadc_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.async_in(pin_async),
		.sync_out(pin_sync)
	);

	sadc_fifo #(
		.WIDTH(RESULT_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.in_valid (sample_valid),
		.in_data  (sample_data),
		.in_ready (sample_ready),
		.out_valid(fifo_valid),
		.out_data (fifo_data),
		.out_ready(fifo_pop)
	);

	// Command is the OR of select and strobe
	assign cmd_n    = pin_sync[SY_CS] | pin_sync[SY_RC];
	assign start    = cmd_n_ff & ~cmd_n & (state_ff == SADC_IDLE);
	assign ext_fall = sclk_prev_ff & ~pin_sync[SY_SCLK];
	assign fifo_pop = (state_ff == SADC_CONV) && (conv_cnt_ff == '0);
	assign bus_on   = ~pin_sync[SY_CS] & pin_sync[SY_RC];
	assign prev_btc = result_ff;

	// Format high gives straight binary
	assign coded = output_format_select_sync(result_ff, pin_sync[SY_FMT]);

	function automatic logic [RESULT_W-1:0] output_format_select_sync(input logic [RESULT_W-1:0] r,
	                                                                    input logic                sb);
		output_format_select_sync = sb ? {~r[RESULT_W-1], r[RESULT_W-2:0]} : r;
	endfunction

	always_comb begin
		nxt_state    = state_ff;
		nxt_conv_cnt = conv_cnt_ff;
		nxt_result   = result_ff;
		unique case (state_ff)
			SADC_IDLE: begin
				if (start) begin
					nxt_state    = SADC_CONV;
					nxt_conv_cnt = CONV_CNT_LAST;
				end
			end
			SADC_CONV: begin
				if (conv_cnt_ff != '0) begin
					nxt_conv_cnt = conv_cnt_ff - 1'b1;
				end else if (fifo_valid) begin
					// Core result lands in the output register
					nxt_result = fifo_data;
					nxt_state  = SADC_SEND;
				end
			end
			SADC_SEND: begin
				// Busy holds until the serial word is gone
				if (!ser_act_ff) begin
					nxt_state = SADC_IDLE;
				end
			end
			default: nxt_state = SADC_IDLE;
		endcase
	end

	// Serial engine; a conversion stalls while the core has no word
	always_comb begin
		nxt_shift   = shift_ff;
		nxt_ser_act = ser_act_ff;
		nxt_div     = div_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_sclk    = sclk_ff;
		if (start) begin
			// Previous word, always twos complement on the serial line
			nxt_shift   = prev_btc;
			nxt_ser_act = ~pin_sync[SY_CSRC];
			nxt_div     = '0;
			nxt_bit_cnt = '0;
			nxt_sclk    = 1'b0;
		end else if (ser_act_ff) begin
			if (div_ff == DIV_LAST) begin
				nxt_div  = '0;
				nxt_sclk = ~sclk_ff;
				if (sclk_ff) begin
					nxt_shift = {shift_ff[RESULT_W-2:0], 1'b0};
					if (bit_cnt_ff == SER_LAST_BIT) begin
						nxt_ser_act = 1'b0;
					end else begin
						nxt_bit_cnt = bit_cnt_ff + 1'b1;
					end
				end
			end else begin
				nxt_div = div_ff + 1'b1;
			end
		end else if (pin_sync[SY_CSRC] && ext_fall) begin
			// External clock: chain input follows the word out
			nxt_shift = {shift_ff[RESULT_W-2:0], pin_sync[SY_CHAIN]};
		end
	end

	always_comb begin
		nxt_pen = bus_on;
		if (byte_select_hi()) begin
			nxt_pdata = {coded[LO_NIB_W-1:0], {LO_NIB_W{1'b0}}};
		end else begin
			nxt_pdata = coded[RESULT_W-1:HI_NIB_LSB];
		end
	end

	function automatic logic byte_select_hi();
		byte_select_hi = pin_sync[SY_BYTE];
	endfunction

	// Conversion state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff    <= SADC_IDLE;
			conv_cnt_ff <= '0;
			result_ff   <= RESULT_RST;
		end else begin
			state_ff    <= nxt_state;
			conv_cnt_ff <= nxt_conv_cnt;
			result_ff   <= nxt_result;
		end
	end

	// Serial engine registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_ff   <= RESULT_RST;
			ser_act_ff <= 1'b0;
			div_ff     <= '0;
			bit_cnt_ff <= '0;
			sclk_ff    <= 1'b0;
		end else begin
			shift_ff   <= nxt_shift;
			ser_act_ff <= nxt_ser_act;
			div_ff     <= nxt_div;
			bit_cnt_ff <= nxt_bit_cnt;
			sclk_ff    <= nxt_sclk;
		end
	end

	// Parallel output register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pdata_ff <= '0;
			pen_ff   <= 1'b0;
		end else begin
			pdata_ff <= nxt_pdata;
			pen_ff   <= nxt_pen;
		end
	end

	// Pin history low after reset, like the synced pins, so release shows no false fall
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_n_ff       <= 1'b0;
			sclk_prev_ff   <= 1'b0;
			sleep_meta_ff  <= 1'b0;
			sleep_ff       <= 1'b0;
			refoff_meta_ff <= 1'b0;
			refoff_ff      <= 1'b0;
		end else begin
			cmd_n_ff       <= cmd_n;
			sclk_prev_ff   <= pin_sync[SY_SCLK];
			sleep_meta_ff  <= analog_sleep;
			sleep_ff       <= sleep_meta_ff;
			refoff_meta_ff <= internal_ref_disable;
			refoff_ff      <= refoff_meta_ff;
		end
	end

	assign busy_n                    = (state_ff == SADC_IDLE);
	assign conv_start                = start;
	assign parallel_result_pins_o    = pdata_ff;
	assign parallel_result_pins_oe_n = {BYTE_W{~pen_ff}};
	assign serial_bit_clock_o        = sclk_ff;
	assign serial_bit_clock_oe_n     = pin_sync[SY_CSRC];
	assign serial_result_out         = shift_ff[RESULT_W-1];
	assign analog_power_down         = sleep_ff;
	assign internal_ref_off          = refoff_ff;
endmodule
`default_nettype wire

//--- rtl/sadc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_sync
	import sadc_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// First stage feeds only the second
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule
`default_nettype wire

//--- sim/sadc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_host_model
	import sadc_pkg::*;
(
	// Clock
	input wire logic              sys_clk,
	// Device answers
	input wire logic              conv_start,
	input wire logic              sclk_pin,
	input wire logic              serial_result_out,
	input wire logic [BYTE_W-1:0] pins_o,
	input wire logic [BYTE_W-1:0] pins_oe_n,
	// Host strobes
	output logic                  chip_select_n,
	output logic                  read_convert,
	output logic                  byte_select,
	output logic                  ext_clk,
	output logic                  chain_bit
);
	logic [RESULT_W-1:0] rx_bits;
	logic                sclk_q;
	int                  pulses = 0;
	int                  starts = 0;

	initial begin
		chip_select_n = 1'b1;
		read_convert = 1'b1;
		byte_select = 1'b0;
		ext_clk = 1'b0;
		chain_bit = 1'b0;
	end

	// Bits taken at the rising edge, midway in the bit time
	always @(posedge sys_clk) begin
		sclk_q <= sclk_pin;
		if (sclk_pin && !sclk_q) begin
			rx_bits <= {rx_bits[RESULT_W-2:0], serial_result_out};
			pulses <= pulses + 1;
		end
		if (conv_start) begin
			starts <= starts + 1;
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic convert(input logic via_cs);
		step(2);
		chip_select_n = via_cs;
		read_convert = 1'b0;
		step(3);
		chip_select_n = 1'b0;
		step(6);
		read_convert = 1'b1;
	endtask

	// A released bus reads back as the inverse, never as a kind guess
	task automatic read_byte(input logic sel, output logic [7:0] d, output logic [7:0] oe);
		byte_select = sel;
		chip_select_n = 1'b0;
		read_convert = 1'b1;
		step(7);
		d = (pins_oe_n == 8'h00) ? pins_o : ~pins_o;
		oe = pins_oe_n;
	endtask

	// Link clock stands low between bursts
	task automatic ext_pulses(input int n, input logic b);
		repeat (n) begin
			chain_bit = b;
			ext_clk = 1'b1;
			step(10);
			ext_clk = 1'b0;
			step(10);
		end
	endtask
endmodule
`default_nettype wire

//--- sim/sadc_port_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_port_monitor
	import sadc_pkg::*;
(
	// Clock and reset
	input wire logic              sys_clk,
	input wire logic              resetn,
	// Host pins
	input wire logic              chip_select_n,
	input wire logic              read_convert,
	input wire logic              byte_select,
	input wire logic              clock_source_select,
	input wire logic              analog_sleep,
	// Device outputs
	input wire logic              busy_n,
	input wire logic [BYTE_W-1:0] parallel_result_pins_o,
	input wire logic [BYTE_W-1:0] parallel_result_pins_oe_n,
	input wire logic              serial_bit_clock_o,
	input wire logic              serial_bit_clock_oe_n,
	input wire logic              conv_start,
	input wire logic              analog_power_down
);
	logic [12:0] low_cnt_ff;
	logic [12:0] nxt_low_cnt;
	logic [3:0]  pulse_ff;
	logic [3:0]  nxt_pulse;
	logic        sclk_q_ff;

	// Long spans counted here; a repetition that long would not unroll
	always_comb begin
		nxt_low_cnt = busy_n ? 13'h0000 : low_cnt_ff + 13'h0001;
		nxt_pulse = busy_n ? 4'h0 : pulse_ff + {3'h0, serial_bit_clock_o & ~sclk_q_ff};
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			low_cnt_ff <= 13'h0000;
			pulse_ff <= 4'h0;
			sclk_q_ff <= 1'b0;
		end else begin
			low_cnt_ff <= nxt_low_cnt;
			pulse_ff <= nxt_pulse;
			sclk_q_ff <= serial_bit_clock_o;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// Seven samples cover two sync flops, the output register and reset release
	sequence quiet_bus_s;
		(chip_select_n || !read_convert) [*7];
	endsequence
	sequence read_bus_s;
		(!chip_select_n && read_convert) [*7];
	endsequence

	oe_uniform_a: assert property (parallel_result_pins_oe_n inside {8'h00, 8'hff})
		else $error("data enables differ");
	bus_float_a: assert property (quiet_bus_s |-> parallel_result_pins_oe_n == 8'hff)
		else $error("data bus not floating");
	bus_drive_a: assert property (read_bus_s |-> parallel_result_pins_oe_n == 8'h00)
		else $error("data bus not driven");
	low_nibble_a: assert property ((byte_select && !chip_select_n && read_convert) [*7]
		|-> parallel_result_pins_o[3:0] == 4'h0) else $error("low nibble not zero");
	start_busy_a: assert property (conv_start |-> ##[0:1] !busy_n ##1 !conv_start)
		else $error("start without busy");
	no_restart_a: assert property (!busy_n [*2] |-> !conv_start) else $error("restart while busy");
	busy_span_a: assert property ($rose(busy_n) |-> low_cnt_ff >= CONV_CYCLES)
		else $error("busy too short");
	pulse_count_a: assert property ($rose(busy_n) && !clock_source_select |-> pulse_ff == 4'(SER_BITS))
		else $error("wrong pulse count");
	idle_clock_a: assert property (busy_n |-> !serial_bit_clock_o) else $error("bit clock runs idle");
	clk_drive_a: assert property (!clock_source_select [*7] |-> !serial_bit_clock_oe_n)
		else $error("bit clock not driven");
	clk_input_a: assert property (clock_source_select [*7] |-> serial_bit_clock_oe_n)
		else $error("bit clock driven");
	sleep_follow_a: assert property (analog_sleep [*7] |-> analog_power_down)
		else $error("sleep not applied");
endmodule

bind sadc_port sadc_port_monitor mon (
	.sys_clk(sys_clk), .resetn(resetn), .chip_select_n(chip_select_n), .read_convert(read_convert),
	.byte_select(byte_select), .clock_source_select(clock_source_select), .analog_sleep(analog_sleep),
	.busy_n(busy_n), .parallel_result_pins_o(parallel_result_pins_o),
	.parallel_result_pins_oe_n(parallel_result_pins_oe_n), .serial_bit_clock_o(serial_bit_clock_o),
	.serial_bit_clock_oe_n(serial_bit_clock_oe_n), .conv_start(conv_start),
	.analog_power_down(analog_power_down)
);
`default_nettype wire

//--- sim/sadc_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_port_tb
	import sadc_pkg::*;
;
	typedef struct packed {
		logic [11:0] word;
		logic        fmt;
		logic        via_cs;
		logic [7:0]  hi;
		logic [7:0]  lo;
	} sadc_row_t;

	// Bytes worked by hand; format high flips the top bit
	sadc_row_t rows [8] = '{
		'{12'ha5c, 1'b0, 1'b0, 8'ha5, 8'hc0}, '{12'h3e1, 1'b1, 1'b0, 8'hbe, 8'h10},
		'{12'h800, 1'b1, 1'b1, 8'h00, 8'h00}, '{12'h7ff, 1'b0, 1'b0, 8'h7f, 8'hf0},
		'{12'hfff, 1'b1, 1'b0, 8'h7f, 8'hf0}, '{12'h001, 1'b0, 1'b1, 8'h00, 8'h10},
		'{12'h5a3, 1'b1, 1'b0, 8'hda, 8'h30}, '{12'h0f0, 1'b0, 1'b0, 8'h0f, 8'h00}};

	logic sys_clk = 1'b0;
	logic resetn, output_format_select, clock_source_select, analog_sleep, internal_ref_disable;
	logic chip_select_n, read_convert, byte_select, ext_clk, chain_bit, sclk_pin, sample_valid;
	logic busy_n, sclk_o, sclk_oe_n, ser_out, sample_ready, conv_start, power_down, ref_off;
	logic [11:0] sample_data, prev;
	logic [7:0]  pins_o, pins_oe_n, d, oe;
	int          bad_count = 0;
	int          comparisons = 0;
	int          p0, s0;

	always #4 sys_clk = ~sys_clk;
	assign sclk_pin = sclk_oe_n ? ext_clk : sclk_o;

	sadc_port uut (
		.sys_clk(sys_clk), .resetn(resetn), .chip_select_n(chip_select_n), .read_convert(read_convert),
		.byte_select(byte_select), .output_format_select(output_format_select),
		.clock_source_select(clock_source_select), .analog_sleep(analog_sleep),
		.internal_ref_disable(internal_ref_disable), .busy_n(busy_n), .parallel_result_pins_o(pins_o),
		.parallel_result_pins_oe_n(pins_oe_n), .serial_bit_clock_i(sclk_pin), .serial_bit_clock_o(sclk_o),
		.serial_bit_clock_oe_n(sclk_oe_n), .serial_result_out(ser_out), .serial_chain_in(chain_bit),
		.sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready),
		.conv_start(conv_start), .analog_power_down(power_down), .internal_ref_off(ref_off));

	sadc_host_model host (
		.sys_clk(sys_clk), .conv_start(conv_start), .sclk_pin(sclk_pin), .serial_result_out(ser_out),
		.pins_o(pins_o), .pins_oe_n(pins_oe_n), .chip_select_n(chip_select_n), .read_convert(read_convert),
		.byte_select(byte_select), .ext_clk(ext_clk), .chain_bit(chain_bit));

	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	task automatic wait_busy();
		for (int k = 0; k < 4000 && busy_n !== 1'b1; k++) host.step(1);
		check(busy_n === 1'b1, "busy stuck low");
	endtask

	// One conversion, a second command while busy, then both byte phases
	task automatic cycle(input logic via_cs, input logic [7:0] hi, input logic [7:0] lo);
		p0 = host.pulses;
		s0 = host.starts;
		host.convert(via_cs);
		host.convert(1'b0);
		wait_busy();
		check(host.pulses - p0 == SER_BITS, "pulse count");
		check(host.rx_bits === prev, "serial word");
		check(host.starts - s0 == 1, "start count");
		host.read_byte(1'b0, d, oe);
		check(d === hi && oe === 8'h00, "high byte");
		host.read_byte(1'b1, d, oe);
		check(d === lo, "low byte");
	endtask

	task automatic stop_test;
		if (bad_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#400000;
		bad_count++;
		stop_test();
	end

	initial begin
		{resetn, output_format_select, clock_source_select, analog_sleep, internal_ref_disable} = 5'h00;
		{sample_valid, sample_data} = 13'h0000;
		prev = RESULT_RST;
		host.step(9);
		check(busy_n === 1'b1 && pins_oe_n === 8'hff && sample_ready === 1'b1 && sclk_o === 1'b0, "reset");
		host.step(1);
		resetn = 1'b1;
		host.step(4);
		sample_valid = 1'b1;
		for (int i = 0; i < 8; i++) begin
			sample_data = rows[i].word;
			host.step(1);
		end
		check(sample_ready === 1'b0, "full buffer accepts");
		check(busy_n === 1'b1 && host.starts == 0, "start after reset");
		sample_valid = 1'b0;
		for (int i = 0; i < 8; i++) begin
			output_format_select = rows[i].fmt;
			cycle(rows[i].via_cs, rows[i].hi, rows[i].lo);
			prev = rows[i].word;
		end
		// Empty buffer must hold busy low until a word arrives
		output_format_select = 1'b0;
		host.convert(1'b0);
		host.step(3000);
		check(busy_n === 1'b0 && sample_ready === 1'b1, "finished without data");
		sample_data = 12'h9c4;
		sample_valid = 1'b1;
		host.step(1);
		sample_valid = 1'b0;
		wait_busy();
		host.read_byte(1'b0, d, oe);
		check(d === 8'h9c, "late word");
		for (int v = 1; v >= 0; v--) begin
			analog_sleep = v[0];
			internal_ref_disable = !v[0];
			host.step(7);
			check(power_down === v[0] && ref_off === !v[0], "analog controls");
		end
		clock_source_select = 1'b1;
		host.step(7);
		check(sclk_oe_n === 1'b1, "bit clock still driven");
		host.ext_pulses(12, 1'b1);
		check(ser_out === 1'b1, "chain ones");
		host.ext_pulses(11, 1'b0);
		check(ser_out === 1'b1, "chain shifted early");
		host.ext_pulses(1, 1'b0);
		check(ser_out === 1'b0, "chain length");
		host.convert(1'b0);
		host.step(20);
		resetn = 1'b0;
		host.step(2);
		check(busy_n === 1'b1 && pins_oe_n === 8'hff, "reset mid conversion");
		s0 = host.starts;
		resetn = 1'b1;
		host.step(10);
		check(busy_n === 1'b1 && host.starts == s0 && pins_oe_n === 8'h00, "after reset release");
		stop_test();
	end
endmodule
`default_nettype wire
